// [hw/sacc_pkg.sv]
// Package with register map, field layout, reset values and types of the converter control.
package sacc_pkg;

	localparam logic [7:0] CHAN_ADDR    = 8'hBB;
	localparam logic [7:0] CONFIG_ADDR  = 8'hBC;
	localparam logic [7:0] RESULT_ADDR  = 8'hBE;
	localparam logic [7:0] CONTROL_ADDR = 8'hE8;

	localparam logic [7:0] CHAN_RESET    = 8'h00;
	localparam logic [7:0] CONFIG_RESET  = 8'hF8;
	localparam logic [7:0] RESULT_RESET  = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// Control register bit positions.
	localparam int CTL_ENABLE_BIT = 7;
	localparam int CTL_TRACK_BIT  = 6;
	localparam int CTL_DONE_BIT   = 5;
	localparam int CTL_BUSY_BIT   = 4;
	localparam int CTL_SRC_LSB    = 0;
	// Config register field positions.
	localparam int CFG_DIV_LSB    = 3;
	localparam int CFG_GAIN_LSB   = 0;
	// Channel register field positions.
	localparam int CHAN_NEG_LSB   = 4;
	localparam int CHAN_POS_LSB   = 0;

	localparam logic [2:0] SRC_SOFTWARE = 3'h0;
	localparam logic [2:0] SRC_TIMER0   = 3'h1;
	localparam logic [2:0] SRC_TIMER2   = 3'h2;
	localparam logic [2:0] SRC_TIMER1   = 3'h3;

	localparam logic [1:0] TRACK_SAR_CLOCKS = 2'h3;
	localparam logic [2:0] RESULT_MSB       = 3'h7;

	typedef enum logic [1:0] {
		SACC_GAIN_HALF,
		SACC_GAIN_ONE,
		SACC_GAIN_TWO,
		SACC_GAIN_FOUR
	} sacc_gain_e;

	typedef struct packed {
		logic       converter_enable_bit;
		logic       track_mode_select;
		logic       conversion_done_flag;
		logic [2:0] start_source_select;
	} sacc_ctrl_s;

	typedef struct packed {
		logic [4:0] sar_clock_divider;
		sacc_gain_e gain_select_field;
	} sacc_cfg_s;

	typedef struct packed {
		logic [3:0] negative_input_select;
		logic [3:0] positive_input_select;
	} sacc_chan_s;

endpackage

// [hw/sacc_top.sv]
// Conversion control for an 8-bit successive-approximation converter.
// How it works
// - Converter runs only while enable bit set.
// - Ground negative input means single-ended mode.
// - Single-ended result is unsigned eight bits.
// - Differential result is two's complement eight bits.
// - Gain half, one, two, four; resets half.
// - SAR clock is system clock over divider+1.
// - Start source chosen by start select field.
// - Busy reads one throughout each conversion.
// - Busy falling edge at completion sets the done flag.
// - Result valid once done flag reads one.
// - Timer 2 overflow byte follows its mode.
// - Normal mode tracks except while converting.
// - Low-power mode tracks three SAR clocks first.
// - Low-power strobe mode tracks while strobe low.
// - Tracking shuts down in standby.
// - Positive mux: pins, sensor, supply; negative: pins, ground.
// - Gain field codes map half to four.
// - Start field codes: software, timers, strobe.
// - Positive select codes; upper six reserved.
// - Negative select top bit selects ground.
`timescale 1ns/1ps
`default_nettype none

module sacc_top
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [7:0]  rdata,
	input  wire logic        timer0_ovf,
	input  wire logic        timer1_ovf,
	input  wire logic        timer2_low_ovf,
	input  wire logic        timer2_high_ovf,
	input  wire logic        timer2_split_mode,
	input  wire logic        external_convert_strobe,
	input  wire logic        standby_mode,
	input  wire logic        comparator_high,
	output logic             converter_powered,
	output logic             track_active,
	output logic             differential_mode,
	output logic      [7:0]  dac_code,
	output logic      [3:0]  positive_input_select,
	output logic      [3:0]  negative_input_select,
	output logic      [1:0]  gain_select_field,
	output logic             conversion_busy_bit,
	output logic             conversion_done_flag,
	output logic             conversion_done_pulse
);

	typedef enum logic [1:0] {
		SACC_IDLE,
		SACC_TRACK,
		SACC_CONVERT
	} sacc_state_e;

	// Short local names for the carrier types, since nothing is imported from the package.
	typedef sacc_pkg::sacc_ctrl_s sacc_ctrl_s;
	typedef sacc_pkg::sacc_cfg_s  sacc_cfg_s;
	typedef sacc_pkg::sacc_chan_s sacc_chan_s;
	typedef sacc_pkg::sacc_gain_e sacc_gain_e;

	sacc_ctrl_s  ctrl_reg;
	sacc_ctrl_s  ctrl_next;
	sacc_cfg_s   cfg_reg;
	sacc_cfg_s   cfg_next;
	sacc_chan_s  chan_reg;
	sacc_chan_s  chan_next;
	logic [7:0]  result_reg;
	logic [7:0]  result_next;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;

	sacc_state_e state_reg;
	sacc_state_e state_next;
	logic [4:0]  div_cnt_reg;
	logic [4:0]  div_cnt_next;
	logic [1:0]  track_cnt_reg;
	logic [1:0]  track_cnt_next;
	logic [2:0]  bit_idx_reg;
	logic [2:0]  bit_idx_next;
	logic [7:0]  trial_reg;
	logic [7:0]  trial_next;
	logic        diff_reg;
	logic        diff_next;
	logic        busy_reg;
	logic        busy_next;
	logic        pulse_reg;
	logic        pulse_next;
	logic        track_reg;
	logic        track_next;

	logic [2:0]  strobe_sync_reg;
	logic        strobe_level_reg;
	logic        strobe_level_next;

	logic        sar_tick;
	logic        start_event;
	logic        strobe_rise;
	logic        use_strobe;
	logic        write_ctrl;
	logic        completes;
	logic        neg_is_ground;

	assign write_ctrl    = wr_stb && (addr == sacc_pkg::CONTROL_ADDR);
	assign use_strobe    = ctrl_reg.start_source_select[2];
	assign neg_is_ground = chan_reg.negative_input_select[3];
	assign sar_tick      = (div_cnt_reg == cfg_reg.sar_clock_divider);
	assign strobe_rise   = strobe_level_next && !strobe_level_reg;
	assign completes     = (state_reg == SACC_CONVERT) && sar_tick && (bit_idx_reg == 3'h0);

	// The first synchroniser stage is only ever read by the second.
	always_ff @(posedge clock or negedge rst_b)
	begin
		// Resetting to the idle high level keeps a false rise away after reset.
		if (!rst_b)
			strobe_sync_reg <= 3'h7;
		else
			strobe_sync_reg <= {strobe_sync_reg[1:0], external_convert_strobe};
	end

	// The filtered strobe level moves only when the last two stages agree.
	always_comb
	begin
		strobe_level_next = strobe_level_reg;
		if (strobe_sync_reg[1] == strobe_sync_reg[2])
			strobe_level_next = strobe_sync_reg[2];
	end

	// Start event selection.
	always_comb
	begin
		start_event = 1'b0;
		if (use_strobe)
			start_event = strobe_rise;
		else
		begin
			unique case (ctrl_reg.start_source_select)
				sacc_pkg::SRC_SOFTWARE:
					start_event = write_ctrl && wdata[sacc_pkg::CTL_BUSY_BIT];
				sacc_pkg::SRC_TIMER0:
					start_event = timer0_ovf;
				sacc_pkg::SRC_TIMER2:
					start_event = timer2_split_mode ? timer2_low_ovf : timer2_high_ovf;
				default:
					start_event = timer1_ovf;
			endcase
		end
	end

	// Conversion sequencer: divider, tracking window and bit trials.
	always_comb
	begin
		state_next     = state_reg;
		div_cnt_next   = sar_tick ? 5'h00 : div_cnt_reg + 5'h01;
		track_cnt_next = track_cnt_reg;
		bit_idx_next   = bit_idx_reg;
		trial_next     = trial_reg;
		diff_next      = diff_reg;
		result_next    = result_reg;
		busy_next      = busy_reg;
		pulse_next     = 1'b0;
		if (wr_stb && (addr == sacc_pkg::RESULT_ADDR))
			result_next = wdata;
		unique case (state_reg)
			SACC_IDLE:
			begin
				if (start_event)
				begin
					diff_next    = !neg_is_ground;
					bit_idx_next = sacc_pkg::RESULT_MSB;
					trial_next   = 8'h80;
					div_cnt_next = 5'h00;
					busy_next    = 1'b1;
					if (ctrl_reg.track_mode_select && !use_strobe)
					begin
						state_next     = SACC_TRACK;
						track_cnt_next = sacc_pkg::TRACK_SAR_CLOCKS - 2'h1;
					end
					else
						state_next = SACC_CONVERT;
				end
			end
			SACC_TRACK:
			begin
				if (sar_tick)
				begin
					if (track_cnt_reg == 2'h0)
						state_next = SACC_CONVERT;
					else
						track_cnt_next = track_cnt_reg - 2'h1;
				end
			end
			SACC_CONVERT:
			begin
				if (sar_tick)
				begin
					// Keep the trial bit if the input sits above the trial level.
					trial_next[bit_idx_reg] = comparator_high;
					if (bit_idx_reg != 3'h0)
					begin
						trial_next[bit_idx_reg - 3'h1] = 1'b1;
						bit_idx_next = bit_idx_reg - 3'h1;
					end
					else
					begin
						// Offset binary from the array becomes two's complement
						// by flipping the sign bit in differential mode.
						result_next = {trial_reg[7:1], comparator_high}
							^ {diff_reg, 7'h00};
						state_next  = SACC_IDLE;
						busy_next   = 1'b0;
						pulse_next  = 1'b1;
					end
				end
			end
			default:
				state_next = SACC_IDLE;
		endcase
		// Disabling aborts the sequence without reporting completion.
		if (!ctrl_reg.converter_enable_bit)
		begin
			state_next   = SACC_IDLE;
			busy_next    = 1'b0;
			pulse_next   = 1'b0;
			div_cnt_next = 5'h00;
			result_next  = result_reg;
			if (wr_stb && (addr == sacc_pkg::RESULT_ADDR))
				result_next = wdata;
		end
	end

	// Tracking switch control.
	always_comb
	begin
		track_next = 1'b0;
		if (ctrl_reg.converter_enable_bit && !standby_mode)
		begin
			if (!ctrl_reg.track_mode_select)
				track_next = (state_next == SACC_IDLE);
			else if (use_strobe)
				track_next = (state_next == SACC_IDLE) && !strobe_level_next;
			else
				track_next = (state_next == SACC_TRACK);
		end
	end

	// Register writes and the sticky done flag.
	always_comb
	begin
		ctrl_next = ctrl_reg;
		cfg_next  = cfg_reg;
		chan_next = chan_reg;
		if (write_ctrl)
		begin
			ctrl_next.converter_enable_bit = wdata[sacc_pkg::CTL_ENABLE_BIT];
			ctrl_next.track_mode_select    = wdata[sacc_pkg::CTL_TRACK_BIT];
			ctrl_next.conversion_done_flag = wdata[sacc_pkg::CTL_DONE_BIT];
			ctrl_next.start_source_select  = wdata[sacc_pkg::CTL_SRC_LSB +: 3];
		end
		if (wr_stb && (addr == sacc_pkg::CONFIG_ADDR))
		begin
			cfg_next.sar_clock_divider = wdata[sacc_pkg::CFG_DIV_LSB +: 5];
			cfg_next.gain_select_field = sacc_gain_e'(wdata[sacc_pkg::CFG_GAIN_LSB +: 2]);
		end
		if (wr_stb && (addr == sacc_pkg::CHAN_ADDR))
		begin
			chan_next.negative_input_select = wdata[sacc_pkg::CHAN_NEG_LSB +: 4];
			chan_next.positive_input_select = wdata[sacc_pkg::CHAN_POS_LSB +: 4];
		end
		// Completion in the same cycle as a clearing write still leaves it set.
		if (pulse_next)
			ctrl_next.conversion_done_flag = 1'b1;
	end

	// Read data stand in the cycle after the strobe only.
	always_comb
	begin
		rdata_next = 8'h00;
		if (rd_stb)
		begin
			unique case (addr)
				sacc_pkg::CONTROL_ADDR:
					rdata_next = {ctrl_reg.converter_enable_bit, ctrl_reg.track_mode_select,
						ctrl_reg.conversion_done_flag, busy_reg, 1'b0,
						ctrl_reg.start_source_select};
				sacc_pkg::CONFIG_ADDR:
					rdata_next = {cfg_reg.sar_clock_divider, 1'b0, cfg_reg.gain_select_field};
				sacc_pkg::CHAN_ADDR:
					rdata_next = chan_reg;
				sacc_pkg::RESULT_ADDR:
					rdata_next = result_reg;
				default:
					rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_reg         <= sacc_ctrl_s'({
				sacc_pkg::CONTROL_RESET[sacc_pkg::CTL_ENABLE_BIT -: 3],
				sacc_pkg::CONTROL_RESET[sacc_pkg::CTL_SRC_LSB +: 3]});
			cfg_reg          <= sacc_cfg_s'({
				sacc_pkg::CONFIG_RESET[sacc_pkg::CFG_DIV_LSB +: 5],
				sacc_pkg::CONFIG_RESET[sacc_pkg::CFG_GAIN_LSB +: 2]});
			chan_reg         <= sacc_pkg::CHAN_RESET;
			result_reg       <= sacc_pkg::RESULT_RESET;
			rdata_reg        <= 8'h00;
			state_reg        <= SACC_IDLE;
			div_cnt_reg      <= 5'h00;
			track_cnt_reg    <= 2'h0;
			bit_idx_reg      <= 3'h0;
			trial_reg        <= 8'h00;
			diff_reg         <= 1'b0;
			busy_reg         <= 1'b0;
			pulse_reg        <= 1'b0;
			track_reg        <= 1'b0;
			strobe_level_reg <= 1'b1;
		end
		else
		begin
			ctrl_reg         <= ctrl_next;
			cfg_reg          <= cfg_next;
			chan_reg         <= chan_next;
			result_reg       <= result_next;
			rdata_reg        <= rdata_next;
			state_reg        <= state_next;
			div_cnt_reg      <= div_cnt_next;
			track_cnt_reg    <= track_cnt_next;
			bit_idx_reg      <= bit_idx_next;
			trial_reg        <= trial_next;
			diff_reg         <= diff_next;
			busy_reg         <= busy_next;
			pulse_reg        <= pulse_next;
			track_reg        <= track_next;
			strobe_level_reg <= strobe_level_next;
		end
	end

	assign rdata                 = rdata_reg;
	assign converter_powered     = ctrl_reg.converter_enable_bit;
	assign track_active          = track_reg;
	assign differential_mode     = diff_reg;
	assign dac_code              = trial_reg;
	assign positive_input_select = chan_reg.positive_input_select;
	assign negative_input_select = chan_reg.negative_input_select;
	assign gain_select_field     = cfg_reg.gain_select_field;
	assign conversion_busy_bit   = busy_reg;
	assign conversion_done_flag  = ctrl_reg.conversion_done_flag;
	assign conversion_done_pulse = pulse_reg;

endmodule

`default_nettype wire

// [testbench/sacc_analog_model.sv]
// Behavioural comparator standing for the selected analog input.
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model
(
	input  wire logic [7:0] level,
	input  wire logic [7:0] dac_code,
	output logic            comparator_high
);
	// The input sits half a code above level, so a tie never decides the result.
	assign comparator_high = {level, 1'b1} > {dac_code, 1'b0};
endmodule
`default_nettype wire

// [testbench/sacc_sva.sv]
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module sacc_sva
(
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_stb,
	input wire logic       standby_mode,
	input wire logic       converter_powered,
	input wire logic       track_active,
	input wire logic       differential_mode,
	input wire logic [3:0] positive_input_select,
	input wire logic [3:0] negative_input_select,
	input wire logic [1:0] gain_select_field,
	input wire logic       conversion_busy_bit,
	input wire logic       conversion_done_flag,
	input wire logic       conversion_done_pulse
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic ctl_wr;
	assign ctl_wr = wr_stb && addr == sacc_pkg::CONTROL_ADDR;
	sequence s_busy_end;
		$fell(conversion_busy_bit) && converter_powered;
	endsequence
	sequence s_done_raise;
		conversion_done_pulse && conversion_done_flag ##1 !conversion_done_pulse;
	endsequence
	// An abort drops busy one cycle after power, so it is excluded from the end sequence.
	a_done_on_fall: assert property (s_busy_end |-> s_done_raise)
		else $error("done not raised at busy fall");
	a_pulse_at_fall: assert property (conversion_done_pulse |-> $fell(conversion_busy_bit))
		else $error("done pulse without busy fall");
	a_flag_sticky: assert property (conversion_done_flag && !ctl_wr |=> conversion_done_flag)
		else $error("done flag dropped by itself");
	a_flag_clear: assert property (ctl_wr && !wdata[5] |=> !conversion_done_flag || conversion_done_pulse)
		else $error("done flag not cleared");
	a_off_idle: assert property (!converter_powered && !$past(converter_powered) |-> !conversion_busy_bit)
		else $error("busy while disabled");
	a_enable_wr: assert property (ctl_wr |=> converter_powered == $past(wdata[7]))
		else $error("enable not taken");
	a_gain_wr: assert property (wr_stb && addr == sacc_pkg::CONFIG_ADDR
		|=> gain_select_field == $past(wdata[1:0]))
		else $error("gain field mismatch");
	a_chan_wr: assert property (wr_stb && addr == sacc_pkg::CHAN_ADDR
		|=> {negative_input_select, positive_input_select} == $past(wdata))
		else $error("channel select mismatch");
	a_diff_latch: assert property ($rose(conversion_busy_bit)
		|-> differential_mode == !negative_input_select[3])
		else $error("wrong input mode");
	a_standby_off: assert property (standby_mode && $past(standby_mode) |-> !track_active)
		else $error("tracking in standby");
endmodule
bind sacc_top sacc_sva i_sva (.clock, .rst_b, .addr, .wdata, .wr_stb, .standby_mode,
	.converter_powered, .track_active, .differential_mode, .positive_input_select,
	.negative_input_select, .gain_select_field, .conversion_busy_bit,
	.conversion_done_flag, .conversion_done_pulse);
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic [3:0]  tmr = 4'h0;
	logic        split = 1'b0;
	logic        strobe = 1'b1;
	logic        standby = 1'b0;
	logic [7:0]  lvl = 8'h00;
	logic [7:0]  rdata, dac;
	logic        cmp, powered, track, diff, busy, done, pulse;
	logic [3:0]  pos_sel, neg_sel, sel, neg;
	logic [1:0]  gain;
	logic [4:0]  d;
	logic [2:0]  src;
	logic        tm;
	logic        rd_d = 1'b0;
	logic [15:0] cnt = 16'h0;
	logic [7:0]  rq[$];
	logic [15:0] lq[$];
	int          err_count = 0;
	int          comparisons = 0;

	always #5 clock = ~clock;

	sacc_top i_dut (.clock, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.timer0_ovf(tmr[0]), .timer1_ovf(tmr[1]), .timer2_low_ovf(tmr[2]),
		.timer2_high_ovf(tmr[3]), .timer2_split_mode(split), .external_convert_strobe(strobe),
		.standby_mode(standby), .comparator_high(cmp), .converter_powered(powered),
		.track_active(track), .differential_mode(diff), .dac_code(dac),
		.positive_input_select(pos_sel), .negative_input_select(neg_sel),
		.gain_select_field(gain), .conversion_busy_bit(busy),
		.conversion_done_flag(done), .conversion_done_pulse(pulse));
	sacc_analog_model i_model (.level(lvl), .dac_code(dac), .comparator_high(cmp));

	task automatic chk_len(input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("Error at %0t: expected %h, got %h", $time, e, g);
		end
	endtask
	task automatic chk_data(input logic [7:0] e, input logic [7:0] g);
		chk_len({8'h00, e}, {8'h00, g});
	endtask
	task automatic stop_test;
		$display("Comparisons %0d, errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		rq.push_back(e);
		@(posedge clock);
		rd_stb <= 1'b0;
	endtask
	task automatic fire;
		if (src == 3'h0)
			wr(sacc_pkg::CONTROL_ADDR, {1'b1, tm, 3'b010, src});
		else if (src[2])
		begin
			@(posedge clock);
			strobe <= 1'b0;
			repeat (6) @(posedge clock);
			strobe <= 1'b1;
		end
		else
		begin
			@(posedge clock);
			tmr <= sel;
			@(posedge clock);
			tmr <= 4'h0;
		end
	endtask

	// The watcher pairs each completion with the oldest expected busy length.
	always @(posedge clock)
	begin
		if (rd_d)
			chk_data(rq.pop_front(), rdata);
		rd_d <= rd_stb;
		if (busy === 1'b1)
			cnt <= cnt + 16'h1;
		else
		begin
			if (pulse === 1'b1)
				chk_len(lq.pop_front(), cnt);
			cnt <= 16'h0;
		end
	end

	initial
	begin
		#500000;
		err_count++;
		stop_test();
	end

	initial
	begin
		void'($urandom(32'h575B));
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		rd(sacc_pkg::CHAN_ADDR, sacc_pkg::CHAN_RESET);
		rd(sacc_pkg::CONFIG_ADDR, sacc_pkg::CONFIG_RESET);
		rd(sacc_pkg::RESULT_ADDR, sacc_pkg::RESULT_RESET);
		rd(sacc_pkg::CONTROL_ADDR, sacc_pkg::CONTROL_RESET);
		chk_data(8'h00, {6'h00, gain});
		wr(8'h55, 8'hFF);
		rd(8'h55, 8'h00);
		for (int i = 0; i < 20; i++)
		begin
			src = (i % 5 == 4) ? {1'b1, 2'($urandom_range(3))} : 3'(i % 5);
			tm = 1'((i / 5) % 2);
			d = (i == 19) ? 5'h1F : 5'($urandom_range(3));
			neg = 4'($urandom_range(15));
			split <= 1'($urandom_range(1));
			wr(sacc_pkg::CONFIG_ADDR, {d, 1'b0, 2'($urandom_range(3))});
			wr(sacc_pkg::CHAN_ADDR, {neg, 4'($urandom_range(9))});
			sel = (src == 3'h1) ? 4'h1 : (src == 3'h3) ? 4'h2 : (src != 3'h2) ? 4'h0 :
				split ? 4'h4 : 4'h8;
			wr(sacc_pkg::CONTROL_ADDR, {1'b1, tm, 3'b000, src});
			rd(sacc_pkg::CONTROL_ADDR, {1'b1, tm, 3'b000, src});
			lvl <= 8'($urandom);
			lq.push_back(((tm && !src[2]) ? 16'hB : 16'h8) * (16'(d) + 16'h1));
			@(posedge clock);
			tmr <= ~sel;
			@(posedge clock);
			tmr <= 4'h0;
			repeat (6) @(posedge clock);
			chk_data(8'h00, {7'h00, busy});
			fire();
			if (!src[2])
			begin
				repeat (2) @(posedge clock);
				fire();
			end
			for (int k = 0; k < 2000 && done !== 1'b1; k++)
				@(posedge clock);
			rd(sacc_pkg::RESULT_ADDR, neg[3] ? lvl : lvl ^ 8'h80);
			rd(sacc_pkg::CONTROL_ADDR, {1'b1, tm, 3'b100, src});
		end
		wr(sacc_pkg::CONTROL_ADDR, 8'h80);
		repeat (3) @(posedge clock);
		chk_data(8'h01, {7'h00, track});
		standby <= 1'b1;
		repeat (3) @(posedge clock);
		chk_data(8'h00, {7'h00, track});
		standby <= 1'b0;
		wr(sacc_pkg::CONTROL_ADDR, 8'h90);
		repeat (2) @(posedge clock);
		wr(sacc_pkg::CONTROL_ADDR, 8'h00);
		wr(sacc_pkg::CONTROL_ADDR, 8'h10);
		repeat (3) @(posedge clock);
		rd(sacc_pkg::CONTROL_ADDR, 8'h00);
		repeat (3) @(posedge clock);
		stop_test();
	end
endmodule
`default_nettype wire
